// ### pkg/srls_pkg.sv
// constants for the latch source selection block
package srls_pkg;
   localparam logic [31:0] ADDR_CONTROL  = 32'h0000_0000;
   localparam logic [31:0] ADDR_ENABLES  = 32'h0000_0004;
   localparam logic [31:0] ADDR_STATUS   = 32'h0000_0008;
   localparam logic [7:0]  CONTROL_RESET = 8'h00;
   localparam logic [7:0]  ENABLES_RESET = 8'h00;
   localparam int BIT_SET_PIN   = 7;
   localparam int BIT_SET_CLK   = 6;
   localparam int BIT_SET_C2    = 5;
   localparam int BIT_SET_C1    = 4;
   localparam int BIT_CLR_PIN   = 3;
   localparam int BIT_CLR_CLK   = 2;
   localparam int BIT_CLR_C2    = 1;
   localparam int BIT_CLR_C1    = 0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ    = 2'h3;
   localparam logic [31:0] WORD_MASK    = 32'h0000_00FF;
endpackage

// ### src/srls_or4.sv
// enable-gated or of four latch sources
module srls_or4 (
   input  wire logic [3:0] src,
   input  wire logic [3:0] en,
   output logic            hit
);
   assign hit = |(src & en);
endmodule

// ### src/srls_source_select.sv
// latch source selection with ahb-lite register access
// Behaviour
// RULE1: with the set-from-pin enable high, a high input pin sets the latch.
// RULE2: with the clear-from-pin enable high, a high input pin resets it.
// RULE3: with the set-from-clock enable high, each pulse clock pulse sets.
// RULE4: with the clear-from-clock enable high, each pulse clock pulse resets.
// RULE5: all eight enables are read/write and clear to zero on reset.
// RULE6: comparator enables add to the sources, all ORed per input.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
module srls_source_select (
   input  wire logic        ref_clk,
   input  wire logic        reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        latch_ext_input,
   input  wire logic        latch_pulse_clock,
   input  wire logic        comp1_out,
   input  wire logic        comp2_out,
   output logic             latch_set,
   output logic             latch_clear,
   output logic [7:0]       latch_control
);
   logic [7:0]  enables_reg;
   logic [7:0]  control_reg;
   logic        wr_pend_reg;
   logic [31:0] wr_addr_reg;
   logic [31:0] rd_data_reg;
   logic        set_hit;
   logic        clr_hit;
   logic        take;
   logic [31:0] rd_next;

   assign take = hsel && hready && htrans[1];

   // read mux for the address phase
   always_comb begin
      rd_next = '0;
      if (haddr == srls_pkg::ADDR_CONTROL) begin
         rd_next = {24'h00_0000, control_reg};
      end else if (haddr == srls_pkg::ADDR_ENABLES) begin
         rd_next = {24'h00_0000, enables_reg}; // RULE5
      end else if (haddr == srls_pkg::ADDR_STATUS) begin
         rd_next = {24'h00_0000, 6'h00, clr_hit, set_hit};
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         rd_data_reg <= '0;
      end else if (take) begin
         wr_pend_reg <= hwrite;
         wr_addr_reg <= haddr;
         rd_data_reg <= hwrite ? '0 : rd_next;
      end else if (hready) begin
         wr_pend_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         enables_reg <= srls_pkg::ENABLES_RESET; // RULE5
      end else if (wr_pend_reg &&
                   wr_addr_reg == srls_pkg::ADDR_ENABLES) begin
         enables_reg <= hwdata[7:0]; // RULE5
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         control_reg <= srls_pkg::CONTROL_RESET;
      end else if (wr_pend_reg &&
                   wr_addr_reg == srls_pkg::ADDR_CONTROL) begin
         control_reg <= hwdata[7:0];
      end
   end

   assign hrdata        = rd_data_reg;
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign latch_control = control_reg;

   // set sources: pin, pulse clock, comp2, comp1
   srls_or4 u_set (
      .src ({latch_ext_input, latch_pulse_clock, comp2_out, comp1_out}),
      .en  (enables_reg[srls_pkg::BIT_SET_PIN:srls_pkg::BIT_SET_C1]),
      .hit (set_hit)
   ); // RULE1 RULE3 RULE6

   srls_or4 u_clr (
      .src ({latch_ext_input, latch_pulse_clock, comp2_out, comp1_out}),
      .en  (enables_reg[srls_pkg::BIT_CLR_PIN:srls_pkg::BIT_CLR_C1]),
      .hit (clr_hit)
   ); // RULE2 RULE4 RULE6

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         latch_set   <= 1'b0;
         latch_clear <= 1'b0;
      end else begin
         latch_set   <= set_hit; // RULE1
         latch_clear <= clr_hit; // RULE2
      end
   end

   set_pin_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE1
      latch_ext_input && enables_reg[srls_pkg::BIT_SET_PIN] |=> latch_set)
      else $error("pin did not set latch");
   clr_pin_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE2
      latch_ext_input && enables_reg[srls_pkg::BIT_CLR_PIN] |=> latch_clear)
      else $error("pin did not clear latch");
   set_clk_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE3
      latch_pulse_clock && enables_reg[srls_pkg::BIT_SET_CLK] |=> latch_set)
      else $error("pulse clock did not set");
   clr_clk_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE4
      latch_pulse_clock && enables_reg[srls_pkg::BIT_CLR_CLK]
      |=> latch_clear)
      else $error("pulse clock did not clear");
   no_en_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
      enables_reg == 8'h00 |=> !latch_set && !latch_clear)
      else $error("output without enable");
   comp_set_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
      (comp1_out && enables_reg[srls_pkg::BIT_SET_C1]) ||
      (comp2_out && enables_reg[srls_pkg::BIT_SET_C2]) |=> latch_set)
      else $error("comparator did not set");
   comp_clr_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE6
      (comp1_out && enables_reg[srls_pkg::BIT_CLR_C1]) ||
      (comp2_out && enables_reg[srls_pkg::BIT_CLR_C2]) |=> latch_clear)
      else $error("comparator did not clear");
   en_write_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
      take && hwrite && haddr == srls_pkg::ADDR_ENABLES
      ##1 1 |=> enables_reg == $past(hwdata[7:0]))
      else $error("enable write lost");
   en_read_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
      take && !hwrite && haddr == srls_pkg::ADDR_ENABLES
      |=> hrdata[7:0] == $past(enables_reg))
      else $error("enable readback wrong");

   // register state only moves on a write or a reset
   en_hold_a: assert property (@(posedge ref_clk) disable iff (reset) // RULE5
      !(take && hwrite && haddr == srls_pkg::ADDR_ENABLES)
      ##1 1 |=> $stable(enables_reg))
      else $error("enables changed without write");
   en_reset_a: assert property (@(posedge ref_clk) // RULE5
      $past(reset) |-> enables_reg == srls_pkg::ENABLES_RESET &&
      !latch_set && !latch_clear)
      else $error("enables not cleared by reset");

   // a disabled source must never reach its input
   set_pin_off_a: assert property (@(posedge ref_clk) // RULE1
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_SET_PIN] &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_SET_CLK]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_SET_C2]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_SET_C1]) |=> !latch_set)
      else $error("disabled pin reached set");
   clr_pin_off_a: assert property (@(posedge ref_clk) // RULE2
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_CLR_PIN] &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_CLR_CLK]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_CLR_C2]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_CLR_C1]) |=> !latch_clear)
      else $error("disabled pin reached clear");
   set_clk_off_a: assert property (@(posedge ref_clk) // RULE3
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_SET_CLK] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_SET_PIN]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_SET_C2]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_SET_C1]) |=> !latch_set)
      else $error("disabled pulse clock reached set");
   clr_clk_off_a: assert property (@(posedge ref_clk) // RULE4
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_CLR_CLK] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_CLR_PIN]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_CLR_C2]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_CLR_C1]) |=> !latch_clear)
      else $error("disabled pulse clock reached clear");
   set_c2_off_a: assert property (@(posedge ref_clk) // RULE6
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_SET_C2] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_SET_PIN]) &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_SET_CLK]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_SET_C1]) |=> !latch_set)
      else $error("disabled comparator 2 reached set");
   set_c1_off_a: assert property (@(posedge ref_clk) // RULE6
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_SET_C1] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_SET_PIN]) &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_SET_CLK]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_SET_C2]) |=> !latch_set)
      else $error("disabled comparator 1 reached set");
   clr_c2_off_a: assert property (@(posedge ref_clk) // RULE6
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_CLR_C2] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_CLR_PIN]) &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_CLR_CLK]) &&
      !(comp1_out && enables_reg[srls_pkg::BIT_CLR_C1]) |=> !latch_clear)
      else $error("disabled comparator 2 reached clear");
   clr_c1_off_a: assert property (@(posedge ref_clk) // RULE6
      disable iff (reset)
      !enables_reg[srls_pkg::BIT_CLR_C1] &&
      !(latch_ext_input && enables_reg[srls_pkg::BIT_CLR_PIN]) &&
      !(latch_pulse_clock && enables_reg[srls_pkg::BIT_CLR_CLK]) &&
      !(comp2_out && enables_reg[srls_pkg::BIT_CLR_C2]) |=> !latch_clear)
      else $error("disabled comparator 1 reached clear");

   set_cv: cover property (@(posedge ref_clk) disable iff (reset)
      latch_set);
   clr_cv: cover property (@(posedge ref_clk) disable iff (reset)
      latch_clear);
   wr_cv: cover property (@(posedge ref_clk) disable iff (reset)
      take && hwrite && haddr == srls_pkg::ADDR_ENABLES);
   comp_cv: cover property (@(posedge ref_clk) disable iff (reset)
      comp1_out && enables_reg[srls_pkg::BIT_SET_C1] ##1 latch_set);
   stat_cv: cover property (@(posedge ref_clk) disable iff (reset)
      take && !hwrite && haddr == srls_pkg::ADDR_STATUS);
endmodule

// ### sim/srls_src_model.sv
// far-side model: input pin, pulse clock and two comparators
module srls_src_model (
   input  wire logic       ref_clk,
   input  wire logic [3:0] pattern,
   output logic            pin,
   output logic            pulse,
   output logic            cmp2,
   output logic            cmp1
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {pin, pulse, cmp2, cmp1} = 4'h0;
   always @(posedge ref_clk) {pin, pulse, cmp2, cmp1} <= pattern;
endmodule

// ### sim/sr_latch_source_select_tb.sv
// self-checking bench for the latch source selection block
module sr_latch_source_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, reset, hsel, hwrite, rdy, pin, pls, c1, c2, ls, lc;
   logic [1:0]  htrans;
   logic [3:0]  pat;
   logic        rsp;
   logic [7:0]  ctl;
   logic [31:0] haddr, hwdata, hrdata, q, e;
   int          failures, n_compared, i, s;

   srls_source_select dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(rdy), .hrdata(hrdata), .hreadyout(rdy),
      .hresp(rsp), .latch_ext_input(pin), .latch_pulse_clock(pls),
      .comp1_out(c1), .comp2_out(c2), .latch_set(ls), .latch_clear(lc),
      .latch_control(ctl));
   srls_src_model src_u (.ref_clk(ref_clk), .pattern(pat), .pin(pin),
      .pulse(pls), .cmp2(c2), .cmp1(c1));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic test_done;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (rdy !== 1'b1 && k < 50);
      if (rdy !== 1'b1) begin
         failures++;
         test_done();
      end
   endtask

   // one single word transfer, q holds read data
   task automatic xfer(input logic w, input logic [31:0] a, d,
                       output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= srls_pkg::HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
      chk({31'h0, rsp}, 32'h0000_0000);
   endtask

   initial begin
      {hsel, hwrite, haddr, hwdata, pat, htrans} = '0;
      reset = 1'b1;
      repeat (10) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      xfer(0, srls_pkg::ADDR_ENABLES, 0, q);
      chk(q, 32'h0000_0000);
      xfer(1, srls_pkg::ADDR_ENABLES, 32'h0000_00FF, q);
      xfer(0, srls_pkg::ADDR_ENABLES, 0, q);
      chk(q, 32'h0000_00FF);
      xfer(1, srls_pkg::ADDR_CONTROL, 32'h0000_00A5, q);
      xfer(0, srls_pkg::ADDR_CONTROL, 0, q);
      chk(q, 32'h0000_00A5);
      chk({24'h00_0000, ctl}, 32'h0000_00A5);
      xfer(0, srls_pkg::ADDR_ENABLES, 0, q);
      chk(q, 32'h0000_00FF);
      xfer(0, 32'h0000_0010, 0, q);
      chk(q, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         for (s = 0; s < 4; s++) begin
            xfer(1, srls_pkg::ADDR_ENABLES, 32'(1 << i), q);
            pat <= 4'(1 << s);
            repeat (3) @(posedge ref_clk);
            e = {30'h0, i == s + 4, i == s};
            #1 chk({30'h0, ls, lc}, e);
         end
      end
      xfer(1, srls_pkg::ADDR_ENABLES, 32'h0000_00FF, q);
      pat <= 4'h1;
      repeat (3) @(posedge ref_clk);
      #1 chk({30'h0, ls, lc}, 32'h0000_0003);
      xfer(0, srls_pkg::ADDR_STATUS, 0, q);
      chk(q, 32'h0000_0003);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      xfer(0, srls_pkg::ADDR_ENABLES, 0, q);
      chk(q, 32'h0000_0000);
      test_done();
   end
endmodule
